// ===== verilog/mrc_top.sv
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module mrc_top
    import mrc_pkg::*;
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // register port
    input  wire logic [7:0]    bus_addr,
    input  wire logic [31:0]   bus_wdata,
    input  wire logic          bus_wr,
    input  wire logic          bus_rd,
    output logic      [31:0]   bus_rdata,
    // the two block clocks, as edge strobes
    input  wire logic          blk_tick0,
    input  wire logic          blk_tick1,
    // clock enables
    input  wire logic          ce_a_in,
    input  wire logic          ce_a_out,
    input  wire logic          ce_b_in,
    input  wire logic          ce_b_out,
    // clears
    input  wire logic          clr_a_in,
    input  wire logic          clr_a_out,
    input  wire logic          clr_b_in,
    input  wire logic          clr_b_out,
    // port a
    input  wire logic          renwe_a,
    input  wire logic [AW-1:0] addr_a,
    input  wire logic [NB-1:0] be_a,
    input  wire logic [DW-1:0] din_a,
    output logic      [DW-1:0] dout_a,
    // port b
    input  wire logic          renwe_b,
    input  wire logic [AW-1:0] addr_b,
    input  wire logic [NB-1:0] be_b,
    input  wire logic [DW-1:0] din_b,
    output logic      [DW-1:0] dout_b
);

    // ****************************************
    // state and control decode
    // ****************************************
    typedef struct packed {
        logic [CTL_W-1:0] ctrl;   // control register
        logic [31:0]      rdata;  // read answer
    } mrc_top_s;

    mrc_top_s st_r;   // current
    mrc_top_s st_nxt; // next

    mrc_clkmode_e mode;      // clocking scheme
    logic         is_io;     // input/output scheme
    logic         is_rw;     // read/write scheme
    logic         sdp;       // simple dual-port
    logic         wide;      // 144-bit arrangement
    logic         wsdp;      // wide and simple
    logic         insel;     // input clock index
    logic         cfg_err;   // illegal arrangement
    logic [1:0]   tk;        // both block clocks
    logic         t_in;      // input clock in io scheme
    logic         t_out;     // output clock in io scheme

    // scheme decode; the spare code falls back to independent
    always_comb begin
        case (st_r.ctrl[CTL_MODE +: 2])
            2'h1: begin
                mode = MRC_INOUT;
            end
            2'h2: begin
                mode = MRC_RDWR;
            end
            default: begin
                mode = MRC_INDEP;
            end
        endcase
    end

    assign is_io = (mode == MRC_INOUT);
    assign is_rw = (mode == MRC_RDWR);
    assign sdp = st_r.ctrl[CTL_SDP];
    assign wide = st_r.ctrl[CTL_WIDE];
    assign wsdp = wide && sdp;
    assign insel = st_r.ctrl[CTL_INSEL];
    assign cfg_err = (wide && !sdp) || (is_rw && !sdp);

    assign tk = {blk_tick1, blk_tick0};
    assign t_in = tk[insel];
    assign t_out = tk[~insel];

    // ****************************************
    // clock, enable and clear routing
    // ****************************************
    logic ai_t, ai_e, ai_c;  // port a inputs
    logic ao_t, ao_e, ao_c;  // port a output
    logic bi_t, bi_e, bi_c;  // port b address and strobe
    logic bd_t, bd_e, bd_c;  // port b data and lanes
    logic bo_t, bo_e, bo_c;  // port b output

    // outside the io scheme, port a inputs on clock 0, b on 1
    assign ai_t = is_io ? t_in : blk_tick0;
    assign ai_e = ce_a_in;
    assign ai_c = clr_a_in;

    // io scheme uses the other clock
    assign ao_t = is_io ? t_out : (is_rw ? blk_tick1 : blk_tick0);
    assign ao_e = is_io ? ce_a_out : (is_rw ? ce_b_in : ce_a_in);
    assign ao_c = is_io ? clr_a_out : (is_rw ? clr_b_in : clr_a_in);

    assign bi_t = is_io ? t_in : blk_tick1;
    assign bi_e = ce_b_in;
    assign bi_c = clr_b_in;

    // wide writes take port b data with the write side
    assign bd_t = wsdp ? ai_t : bi_t;
    assign bd_e = wsdp ? ai_e : bi_e;
    assign bd_c = wsdp ? ai_c : bi_c;

    assign bo_t = is_io ? t_out : blk_tick1;
    assign bo_e = is_io ? ce_b_out : ce_b_in;
    assign bo_c = is_io ? clr_b_out : clr_b_in;

    // ****************************************
    // input registers
    // ****************************************
    logic          renwe_qa;  // registered port a strobe
    logic [AW-1:0] addr_qa;   // registered port a address
    logic [NB-1:0] be_qa;     // registered port a lanes
    logic [DW-1:0] din_qa;    // registered port a data
    logic          cap_a;     // port a captured
    logic          renwe_qb;  // registered port b strobe
    logic [AW-1:0] addr_qb;   // registered port b address
    logic [NB-1:0] be_qb;     // registered port b lanes
    logic [DW-1:0] din_qb;    // registered port b data
    logic          cap_bc;    // port b captured
    logic [AW:0]   keep_bc;   // clear-immune bits

    mrc_reg #(.W(1 + AW + NB + DW)) u_in_a (
        .mclk (mclk),
        .rst_n(rst_n),
        .tick (ai_t),
        .en   (ai_e),
        .clr  (ai_c),
        .keep ('0),
        .d    ({renwe_a, addr_a, be_a, din_a}),
        .q    ({renwe_qa, addr_qa, be_qa, din_qa}),
        .cap  (cap_a)
    );

    assign keep_bc = {sdp, {AW{1'b0}}};

    mrc_reg #(.W(1 + AW)) u_in_bc (
        .mclk (mclk),
        .rst_n(rst_n),
        .tick (bi_t),
        .en   (bi_e),
        .clr  (bi_c),
        .keep (keep_bc),
        .d    ({renwe_b, addr_b}),
        .q    ({renwe_qb, addr_qb}),
        .cap  (cap_bc)
    );

    mrc_reg #(.W(NB + DW)) u_in_bd (
        .mclk (mclk),
        .rst_n(rst_n),
        .tick (bd_t),
        .en   (bd_e),
        .clr  (bd_c),
        .keep ('0),
        .d    ({be_b, din_b}),
        .q    ({be_qb, din_qb}),
        .cap  ()
    );

    // ****************************************
    // byte lanes and array
    // ****************************************
    // lane mask; undriven enables read as all ones
    function automatic logic [DW-1:0] be_mask(
        input logic [NB-1:0] be,
        input logic          use_be,
        input logic          nopar
    );
        logic [DW-1:0] m;
        m = '0;
        for (int i = 0; i < NB; i++) begin
            if (nopar) begin
                m[i * LANE_NP +: LANE_NP] = {LANE_NP{be[i] | ~use_be}};
            end else begin
                m[i * LANE_P +: LANE_P] = {LANE_P{be[i] | ~use_be}};
            end
        end
        return m;
    endfunction

    logic [DW-1:0] wmask_a;  // port a write lanes
    logic [DW-1:0] wmask_b;  // port b write lanes
    logic [AW-1:0] wrow_a;   // port a write row
    logic [AW-1:0] wrow_b;   // port b write row
    logic [AW-1:0] rrow_a;   // port a read row
    logic [AW-1:0] rrow_b;   // port b read row
    logic          wr_a;     // port a write pulse
    logic          wr_b;     // port b write pulse
    logic          rd_a;     // port a reading
    logic          rd_b;     // port b reading

    assign wmask_a = be_mask(be_qa, st_r.ctrl[CTL_BEUSE], st_r.ctrl[CTL_NOPAR]);
    assign wmask_b = be_mask(be_qb, st_r.ctrl[CTL_BEUSE], st_r.ctrl[CTL_NOPAR]);

    // wide words sit in an even and an odd row
    assign wrow_a = wsdp ? {addr_qa[AW-2:0], 1'b0} : addr_qa;
    assign wrow_b = wsdp ? {addr_qa[AW-2:0], 1'b1} : addr_qb;
    assign rrow_a = wsdp ? {addr_qb[AW-2:0], 1'b0} : addr_qa;
    assign rrow_b = wsdp ? {addr_qb[AW-2:0], 1'b1} : addr_qb;

    // one strobe selects write or read
    assign wr_a = cap_a && renwe_qa && !cfg_err;
    assign wr_b = (wsdp ? (cap_a && renwe_qa) : (cap_bc && renwe_qb && !sdp)) && !cfg_err;
    assign rd_a = sdp ? (wide && renwe_qb) : !renwe_qa;
    assign rd_b = sdp ? renwe_qb : !renwe_qb;

    logic [DW-1:0] mem [WORDS];

    always_ff @(posedge mclk) begin
        if (wr_a) begin
            mem[wrow_a] <= (mem[wrow_a] & ~wmask_a) | (din_qa & wmask_a);
        end
        // a same-row collision leaves port b's word
        if (wr_b) begin
            mem[wrow_b] <= (mem[wrow_b] & ~wmask_b) | ((wsdp ? din_qb : din_qb) & wmask_b);
        end
    end

    // ****************************************
    // output registers
    // ****************************************
    // 72-bit read paths
    mrc_out u_out_a (
        .mclk  (mclk),
        .rst_n (rst_n),
        .tick  (ao_t),
        .en    (ao_e),
        .clr   (ao_c),
        .bypass(st_r.ctrl[CTL_BYP_A]),
        .rd    (rd_a),
        .din   (mem[rrow_a]),
        .dout  (dout_a)
    );

    mrc_out u_out_b (
        .mclk  (mclk),
        .rst_n (rst_n),
        .tick  (bo_t),
        .en    (bo_e),
        .clr   (bo_c),
        .bypass(st_r.ctrl[CTL_BYP_B]),
        .rd    (rd_b),
        .din   (mem[rrow_b]),
        .dout  (dout_b)
    );

    // ****************************************
    // register port
    // ****************************************
    // writes take effect next edge; reads answer one cycle on
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = '0;
        if (bus_wr && bus_addr == CTRL_OFS) begin
            st_nxt.ctrl = bus_wdata[CTL_W-1:0];
        end
        if (bus_rd) begin
            case (bus_addr)
                CTRL_OFS: begin
                    st_nxt.rdata = 32'(st_r.ctrl);
                end
                STAT_OFS: begin
                    st_nxt.rdata[ST_ERR] = cfg_err;
                    st_nxt.rdata[ST_WEA] = renwe_qa;
                    st_nxt.rdata[ST_WEB] = renwe_qb;
                end
                default: begin
                    st_nxt.rdata = '0;
                end
            endcase
        end
    end

    // register the copy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.ctrl <= CTRL_RST;
            st_r.rdata <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata = st_r.rdata;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_edge_a;
        mode == MRC_INDEP && blk_tick0 && ce_a_in && !clr_a_in;
    endsequence
    sequence s_edge_rd;
        is_rw && blk_tick1 && ce_b_in && !clr_b_in;
    endsequence
    sequence s_lane0_keep;
        wr_a && !wmask_a[0] && !(wr_b && wrow_b == wrow_a);
    endsequence

    indep_clk_a: assert property (s_edge_a |=> cap_a)
        else $error("port a missed its clock edge");
    rd_clk_a: assert property (s_edge_rd |=> cap_bc)
        else $error("read side missed the read clock");
    lane_keep_a: assert property (s_lane0_keep |=> mem[$past(wrow_a)][0] == $past(mem[wrow_a][0]))
        else $error("disabled lane was written");
    lane_write_a: assert property (wr_a && wmask_a[0] && !wr_b |=> mem[$past(wrow_a)][0] == $past(din_qa[0]))
        else $error("enabled lane not written");
    be_default_a: assert property (!st_r.ctrl[CTL_BEUSE] |-> &wmask_a[NB*LANE_NP-1:0])
        else $error("undriven lanes not all enabled");
    lane8_a: assert property (st_r.ctrl[CTL_NOPAR] && st_r.ctrl[CTL_BEUSE] && !be_qa[1] |-> wmask_a[15:8] == 8'h00)
        else $error("second byte lane not gated");
    cfg_block_a: assert property (cfg_err |-> !wr_a && !wr_b)
        else $error("write in an illegal arrangement");
    rden_noclr_a: assert property (sdp && !(bi_t && bi_e) |=> $stable(renwe_qb))
        else $error("read strobe register disturbed");
    clr_out_a: assert property (mode == MRC_INDEP && clr_a_in |=> dout_a == '0)
        else $error("port a output not cleared");

endmodule

// ===== verilog/mrc_pkg.sv
package mrc_pkg;

    // ****************************************
    // array geometry
    // ****************************************
    localparam int AW    = 13;    // word address, 8K rows
    localparam int WORDS = 8192;  // rows of 72 bits
    localparam int DW    = 72;    // data path per port
    localparam int NB    = 8;     // byte lanes per port
    localparam int LANE_P  = 9;   // lane width with parity
    localparam int LANE_NP = 8;   // lane width without parity

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;  // control, rw
    localparam logic [7:0] STAT_OFS = 8'h04;  // status, ro

    // control fields
    localparam int CTL_W     = 9;
    localparam int CTL_MODE  = 0;  // two bits, clocking scheme
    localparam int CTL_SDP   = 2;  // simple dual-port operation
    localparam int CTL_WIDE  = 3;  // 4K x 144 arrangement
    localparam int CTL_BYP_A = 4;  // bypass port a output register
    localparam int CTL_BYP_B = 5;  // bypass port b output register
    localparam int CTL_INSEL = 6;  // clock of input registers
    localparam int CTL_BEUSE = 7;  // byte enables driven
    localparam int CTL_NOPAR = 8;  // 8-bit lanes, no parity
    localparam logic [CTL_W-1:0] CTRL_RST = 9'h000;

    // status fields
    localparam int ST_ERR = 0;  // illegal arrangement
    localparam int ST_WEA = 1;  // port a held in write
    localparam int ST_WEB = 2;  // port b held in write

    // clocking schemes
    typedef enum logic [1:0] {
        MRC_INDEP,
        MRC_INOUT,
        MRC_RDWR
    } mrc_clkmode_e;

endpackage

// ===== verilog/mrc_reg.sv
`timescale 1ns/100ps
module mrc_reg
    import mrc_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // capture control
    input  wire logic         tick,  // edge of the selected block clock
    input  wire logic         en,    // clock enable of this group
    input  wire logic         clr,   // clear of this group
    input  wire logic [W-1:0] keep,  // bits the clear leaves alone
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q,
    output logic              cap    // pulse after a capture
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [W-1:0] q;    // registered group
        logic         cap;  // captured on last edge
    } mrc_reg_s;

    mrc_reg_s st_r;   // current
    mrc_reg_s st_nxt; // next

    // capture on the block clock edge, clear wins
    always_comb begin
        st_nxt = st_r;
        st_nxt.cap = 1'b0;
        if (tick && en) begin
            st_nxt.q = d;
            st_nxt.cap = !clr;
        end
        if (clr) begin
            st_nxt.q = st_nxt.q & keep;
        end
    end

    // register the copy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;
    assign cap = st_r.cap;

    // ****************************************
    // checks
    // ****************************************
    hold_en_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !clr && !(tick && en) |=> $stable(q))
        else $error("register moved without an enabled edge");
    clr_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clr |=> ((q & ~$past(keep)) == '0))
        else $error("clear left a bit set");

endmodule

// ===== verilog/mrc_out.sv
`timescale 1ns/100ps
module mrc_out
    import mrc_pkg::*;
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // capture control
    input  wire logic          tick,    // edge of the output clock
    input  wire logic          en,      // output clock enable
    input  wire logic          clr,     // output clear
    input  wire logic          bypass,  // no output register stage
    input  wire logic          rd,      // a read is addressed
    // data
    input  wire logic [DW-1:0] din,     // array word
    output logic      [DW-1:0] dout
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [DW-1:0] dout;  // read data
    } mrc_out_s;

    mrc_out_s st_r;   // current
    mrc_out_s st_nxt; // next

    // bypass follows the array, else wait for the output clock
    always_comb begin
        st_nxt = st_r;
        if (bypass) begin
            if (rd) begin
                st_nxt.dout = din;
            end
        end else if (tick && en && rd) begin
            st_nxt.dout = din;
        end
        if (clr) begin
            st_nxt.dout = '0;
        end
    end

    // register the copy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.dout;

    // ****************************************
    // checks
    // ****************************************
    byp_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        bypass && rd && !clr |=> dout == $past(din))
        else $error("bypassed read data late");
    out_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !bypass && !(tick && en) && !clr |=> $stable(dout))
        else $error("output register moved off its clock");

endmodule

// ===== test/mrc_user.sv
`timescale 1ns/100ps
module mrc_user
    import mrc_pkg::*;
(
    // clock
    input  wire logic          mclk,
    // block clock strobes
    output logic               tick0,
    output logic               tick1,
    // port a lines
    output logic               renwe_a,
    output logic [AW-1:0]      addr_a,
    output logic [NB-1:0]      be_a,
    output logic [DW-1:0]      din_a,
    // port b lines
    output logic               renwe_b,
    output logic [AW-1:0]      addr_b,
    output logic [NB-1:0]      be_b,
    output logic [DW-1:0]      din_b
);
    // ****************************************
    // user logic model
    // ****************************************
    // quiet at time zero: no block edges
    initial begin
        {tick0, tick1, renwe_a, renwe_b} = 4'h0;
        {addr_a, addr_b, be_a, be_b} = '0;
        {din_a, din_b} = '0;
    end

    // one access lasting a single block edge
    task automatic acc(input logic pb, input logic [1:0] tk, input logic we,
                       input logic [AW-1:0] ad, input logic [NB-1:0] be, input logic [DW-1:0] d);
        @(posedge mclk);
        {tick1, tick0} <= tk;
        if (pb) begin
            {renwe_b, addr_b, be_b, din_b} <= {we, ad, be, d};
        end else begin
            {renwe_a, addr_a, be_a, din_a} <= {we, ad, be, d};
        end
        @(posedge mclk);
        {tick1, tick0} <= 2'h0;
        // released lines flip, so a stale value is never read as good
        if (pb) begin
            {addr_b, be_b, din_b} <= ~{ad, be, d};
        end else begin
            {addr_a, be_a, din_a} <= ~{ad, be, d};
        end
    endtask
endmodule

// ===== test/dual_port_ram_clocking_tb.sv
`timescale 1ns/100ps
module dual_port_ram_clocking_tb
    import mrc_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    logic          mclk, rst_n, bus_wr, bus_rd, tick0, tick1, renwe_a, renwe_b;
    logic [7:0]    bus_addr;
    logic [31:0]   bus_wdata, bus_rdata, rd, lfsr_r;
    logic [3:0]    ce, clr;   // {b_out, b_in, a_out, a_in}
    logic [AW-1:0] addr_a, addr_b;
    logic [NB-1:0] be_a, be_b, be;
    logic [DW-1:0] din_a, din_b, dout_a, dout_b, d;
    logic [DW-1:0] mem [0:WORDS-1];  // expected array contents
    logic          nop, beuse;
    int            miscompares, tests_run, cycles;
    logic [31:0]   stat_tbl [4] = '{32'h008, 32'h002, 32'h00c, 32'h006};

    mrc_top mrc_top_inst (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .blk_tick0(tick0), .blk_tick1(tick1),
        .ce_a_in(ce[0]), .ce_a_out(ce[1]), .ce_b_in(ce[2]), .ce_b_out(ce[3]), .clr_a_in(clr[0]),
        .clr_a_out(clr[1]), .clr_b_in(clr[2]), .clr_b_out(clr[3]), .renwe_a(renwe_a), .addr_a(addr_a),
        .be_a(be_a), .din_a(din_a), .dout_a(dout_a), .renwe_b(renwe_b), .addr_b(addr_b), .be_b(be_b),
        .din_b(din_b), .dout_b(dout_b));
    mrc_user mrc_user_inst (.mclk(mclk), .tick0(tick0), .tick1(tick1), .renwe_a(renwe_a), .addr_a(addr_a),
        .be_a(be_a), .din_a(din_a), .renwe_b(renwe_b), .addr_b(addr_b), .be_b(be_b), .din_b(din_b));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // small address pool with the top row as a corner
    function automatic logic [AW-1:0] adr(input int i);
        return (i == 7) ? 13'h1fff : AW'(i);
    endfunction
    // enabled lanes take new data, 9-bit lanes or 8-bit without parity
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                            input logic [NB-1:0] b, input logic np);
        for (int i = 0; i < NB; i++) begin
            if (b[i] && np) o[LANE_NP*i +: LANE_NP] = n[LANE_NP*i +: LANE_NP];
            else if (b[i]) o[LANE_P*i +: LANE_P] = n[LANE_P*i +: LANE_P];
        end
        return o;
    endfunction
    task automatic rnd();
        repeat (3) begin
            lfsr_r = lfsr(lfsr_r);
            d = {d[39:0], lfsr_r};
        end
    endtask
    task automatic chk72(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        chk72(DW'(got), DW'(exp));
    endtask
    task automatic bw(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        {bus_addr, bus_wdata, bus_wr} <= {a, v, 1'b1};
        @(posedge mclk);
        bus_wr <= 1'b0;
        nop = (a == CTRL_OFS) ? v[CTL_NOPAR] : nop;
        beuse = (a == CTRL_OFS) ? v[CTL_BEUSE] : beuse;
    endtask
    // answer stands only in the cycle after the strobe
    task automatic br(input logic [7:0] a);
        @(posedge mclk);
        {bus_addr, bus_rd} <= {a, 1'b1};
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 rd = bus_rdata;
    endtask
    // a write lands only if the input enable of that port was high
    task automatic wr(input logic p, input logic [AW-1:0] a, input logic [NB-1:0] b);
        mrc_user_inst.acc(p, p ? 2'b10 : 2'b01, 1'b1, a, b, d);
        if (ce[2*p]) mem[a] = merge(mem[a], d, beuse ? b : 8'hff, nop);
        repeat (2) @(posedge mclk);
    endtask
    task automatic rdp(input logic p, input logic [1:0] tk, input logic [AW-1:0] a);
        mrc_user_inst.acc(p, tk, 1'b0, a, 8'hff, '0);
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // hang guard, the run needs a few hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
        {ce, clr, rst_n, nop, beuse} = {8'hf0, 3'b000};
        lfsr_r = 32'h20;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        br(CTRL_OFS); chk32(rd, 32'h0);
        bw(CTRL_OFS, 32'h0b0);
        br(CTRL_OFS); chk32(rd, 32'h0b0);
        br(8'h08); chk32(rd, 32'h0);
        // seed the pool with whole words
        for (int i = 0; i < 8; i++) begin
            rnd();
            wr(i[0], adr(i), 8'hff);
        end
        // random lane mixes, read back through the other port
        for (int k = 0; k < 28; k++) begin
            rnd();
            be = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : d[11:4];
            if (k == 20) bw(CTRL_OFS, 32'h1b0);
            wr(d[0], adr(int'(d[3:1])), be);
            rdp(~d[0], d[0] ? 2'b01 : 2'b10, adr(int'(d[3:1])));
            chk72(d[0] ? dout_a : dout_b, mem[adr(int'(d[3:1]))]);
        end
        // unused lane enables write the whole word
        bw(CTRL_OFS, 32'h030);
        rnd();
        wr(1'b0, adr(2), 8'h00);
        rdp(1'b1, 2'b10, adr(2)); chk72(dout_b, mem[adr(2)]);
        // input enable low: write is lost
        rnd();
        ce[0] <= 1'b0;
        wr(1'b0, adr(3), 8'hff);
        ce[0] <= 1'b1;
        rdp(1'b0, 2'b01, adr(3)); chk72(dout_a, mem[adr(3)]);
        rdp(1'b1, 2'b10, adr(4));
        // clear of port a leaves port b alone
        @(posedge mclk) clr[0] <= 1'b1;
        @(posedge mclk) clr[0] <= 1'b0;
        #1 chk72(dout_a, '0);
        // cleared address row 0 is read again through the bypass
        @(posedge mclk);
        #1 chk72(dout_a, mem[adr(0)]);
        repeat (2) @(posedge mclk);
        chk72(dout_b, mem[adr(4)]);
        // registered output needs a second output edge
        bw(CTRL_OFS, 32'h080);
        rdp(1'b0, 2'b01, adr(5)); chk72(dout_a, mem[adr(0)]);
        rdp(1'b0, 2'b01, adr(5)); chk72(dout_a, mem[adr(5)]);
        // input/output clocks, output enable gates the load
        bw(CTRL_OFS, 32'h081);
        rdp(1'b0, 2'b01, adr(6)); chk72(dout_a, mem[adr(5)]);
        ce[1] <= 1'b0;
        rdp(1'b0, 2'b10, adr(6)); chk72(dout_a, mem[adr(5)]);
        ce[1] <= 1'b1;
        rdp(1'b0, 2'b10, adr(6)); chk72(dout_a, mem[adr(6)]);
        // illegal arrangements flag an error
        for (int k = 0; k < 4; k++) begin
            bw(CTRL_OFS, stat_tbl[k]);
            br(STAT_OFS); chk32(rd & 32'h1, (k < 2) ? 32'h1 : 32'h0);
        end
        wrap_up();
    end
endmodule
